// [core/sbt_cfg.svh]
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// I/O ring geometry
`define SBT_N_IO 36
`define SBT_N_IN 49
`define SBT_BSR_LEN 86
// Output-bus control cell sits at the top of the boundary chain
`define SBT_OE_CELL 85

////////////////////////////////////////////////////////////////////////////////
// Register widths
`define SBT_IR_W 3
`define SBT_ID_W 32

////////////////////////////////////////////////////////////////////////////////
// Instruction codes; the three codes not listed are reserved
`define SBT_OP_EXTEST 3'h0
`define SBT_OP_IDCODE 3'h1
`define SBT_OP_SAMPLE_Z 3'h2
`define SBT_OP_SAMPLE 3'h4
`define SBT_OP_BYPASS 3'h7

// Pattern parked in the instruction shifter at capture
`define SBT_IR_CAPTURE 3'h1

// Identification code; value is arbitrary, bit 0 kept high as scan requires
`define SBT_ID_DEFAULT 32'h0ABC_D001

////////////////////////////////////////////////////////////////////////////////
// Reset and capture values
`define SBT_OE_CELL_RST 1'h1
`define SBT_BYPASS_CAPTURE 1'h0

`endif

// [core/sbt_pkg.sv]
`include "sbt_cfg.svh"

package sbt_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Scan controller states, one-hot
	typedef enum logic [15:0] {
		ST_TLR = 16'h0001,
		ST_RTI = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} sbt_state_t;

	// Data register picked by the current instruction
	typedef enum logic [2:0] {
		SEL_BYP = 3'h1,
		SEL_ID = 3'h2,
		SEL_BSR = 3'h4
	} sbt_sel_t;

	////////////////////////////////////////////////////////////////////////////
	// Pin ring as seen by the boundary cells; io in the low bits
	typedef struct packed {
		logic [`SBT_N_IN-1:0] inp;
		logic [`SBT_N_IO-1:0] io;
	} sbt_ring_t;

	// Full boundary chain: control cell on top of the ring cells
	typedef struct packed {
		logic oe_cell;
		sbt_ring_t ring;
	} sbt_bsr_t;

	////////////////////////////////////////////////////////////////////////////
	// State on the rising scan clock edge
	typedef struct packed {
		sbt_state_t state;
		logic [`SBT_IR_W-1:0] ir_sh;
		logic [`SBT_IR_W-1:0] instr;
		logic bypass;
		logic [`SBT_ID_W-1:0] id_sh;
		sbt_bsr_t bsr_sh;
		sbt_bsr_t preload;
		logic upd_tgl;
		sbt_ring_t smp1;
		sbt_ring_t smp2;
		sbt_ring_t smp3;
		sbt_ring_t filt;
	} sbt_tck_t;

	// State on the falling scan clock edge
	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} sbt_fall_t;

	// State in the system clock domain
	typedef struct packed {
		logic tgl_s1;
		logic tgl_s2;
		logic tgl_s3;
		logic tgl_seen;
		logic [`SBT_IR_W-1:0] instr;
		sbt_bsr_t preload;
		logic [`SBT_N_IO-1:0] pin_out;
		logic pin_oe;
	} sbt_sys_t;

endpackage : sbt_pkg

// [core/sbt_tap.sv]
`timescale 1ns/1ps
`include "sbt_cfg.svh"

// Contract
// [R1] Inputs sampled on scan clock rise; outputs change on scan clock fall.
// [R2] Mode select, sampled each rising scan edge, steers the state machine.
// [R3] Mode select and serial input read high when left open.
// [R4] Serial input enters the selected register MSB; serial output is its LSB.
// [R5] Serial output driver enabled only in shifting states.
// [R6] Five rising edges with mode select high reset the test logic.
// [R7] Test reset leaves normal memory operation untouched.
// [R8] Power-up resets test logic so serial output starts undriven.
// [R9] Unused port: board ties scan clock low, serial output left open.
// [R10] Exactly one register sits in the scan path, chosen by the instruction.
// [R11] Instruction register is three bits, loaded serially when selected.
// [R12] Instruction register holds identification code after power-up and test reset.
// [R13] Capture-IR loads binary 01 into the two instruction LSBs.
// [R14] Instructions shift in Shift-IR and take effect at Update-IR.
// [R15] Three of eight codes are reserved; controller never loads them. Here Update-IR loads any code, and the reserved ones select bypass.
// [R16] Bypass is one bit and captures low under the bypass instruction.
// [R17] Boundary register has a cell for every input and bidirectional ball.
// [R18] Capture-DR loads ring values into boundary register; Shift-DR shifts them.
// [R19] External-test, sample/preload and sample-outputs-off all capture the ring.
// [R20] Identification instruction loads and shifts a hardwired 32-bit code.
// [R21] External test drives preloaded cell values onto system outputs.
// [R22] Sample-outputs-off scans the boundary register and floats every memory output.
// [R23] Sample/preload snapshots pins; preloaded values held until another test instruction.
// [R24] Control cell enables outputs under external test; preset high at reset.
// [R25] Bypass instruction puts the single bypass bit alone in the scan path.
// [R26] State machine follows the standard sixteen-state sequence on mode select.
module sbt_tap #(
	parameter logic [`SBT_ID_W-1:0] ID_CODE = `SBT_ID_DEFAULT
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire sbt_pkg::sbt_ring_t ring_in,
	input wire logic [`SBT_N_IO-1:0] func_out,
	input wire logic func_oe,
	output logic [`SBT_N_IO-1:0] pin_out,
	output logic pin_oe
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Standard controller transitions on the sampled mode select
	function automatic sbt_pkg::sbt_state_t next_state(input sbt_pkg::sbt_state_t s, input logic m);
		sbt_pkg::sbt_state_t ns;
		ns = sbt_pkg::ST_TLR;
		case (s)
			sbt_pkg::ST_TLR: ns = m ? sbt_pkg::ST_TLR : sbt_pkg::ST_RTI;
			sbt_pkg::ST_RTI: ns = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
			sbt_pkg::ST_SEL_DR: ns = m ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
			sbt_pkg::ST_CAP_DR: ns = m ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_SH_DR: ns = m ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_EX1_DR: ns = m ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PAU_DR;
			sbt_pkg::ST_PAU_DR: ns = m ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PAU_DR;
			sbt_pkg::ST_EX2_DR: ns = m ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_UPD_DR: ns = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
			sbt_pkg::ST_SEL_IR: ns = m ? sbt_pkg::ST_TLR : sbt_pkg::ST_CAP_IR;
			sbt_pkg::ST_CAP_IR: ns = m ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_SH_IR: ns = m ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_EX1_IR: ns = m ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PAU_IR;
			sbt_pkg::ST_PAU_IR: ns = m ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PAU_IR;
			sbt_pkg::ST_EX2_IR: ns = m ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_UPD_IR: ns = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
			default: ns = sbt_pkg::ST_TLR;
		endcase
		return ns;
	endfunction : next_state

	// Reserved codes fall back to bypass so the chain length stays defined
	function automatic sbt_pkg::sbt_sel_t dr_select(input logic [`SBT_IR_W-1:0] op);
		sbt_pkg::sbt_sel_t sel;
		sel = sbt_pkg::SEL_BYP;
		case (op)
			`SBT_OP_IDCODE: sel = sbt_pkg::SEL_ID; // R20
			`SBT_OP_EXTEST: sel = sbt_pkg::SEL_BSR; // R21
			`SBT_OP_SAMPLE: sel = sbt_pkg::SEL_BSR; // R19
			`SBT_OP_SAMPLE_Z: sel = sbt_pkg::SEL_BSR; // R22
			`SBT_OP_BYPASS: sel = sbt_pkg::SEL_BYP; // R25
			default: sel = sbt_pkg::SEL_BYP; // R15
		endcase
		return sel;
	endfunction : dr_select

	// Instructions whose update stage latches the preload register
	function automatic logic loads_preload(input logic [`SBT_IR_W-1:0] op);
		return (op == `SBT_OP_EXTEST) || (op == `SBT_OP_SAMPLE);
	endfunction : loads_preload

	////////////////////////////////////////////////////////////////////////////
	// Scan clock rising edge: controller, instruction and data registers

	sbt_pkg::sbt_tck_t r;
	sbt_pkg::sbt_tck_t next_r;
	sbt_pkg::sbt_sel_t sel;

	assign sel = dr_select(r.instr); // R10

	// Next state of the rising-edge logic
	always_comb begin
		next_r = r;
		// Ring pins are asynchronous to the scan clock; a value counts once it stands two samples
		next_r.smp1 = ring_in;
		next_r.smp2 = r.smp1;
		next_r.smp3 = r.smp2;
		if (r.smp2 == r.smp3) begin
			next_r.filt = r.smp3;
		end
		next_r.state = next_state(r.state, tms); // R2 R26
		case (r.state)
			sbt_pkg::ST_CAP_IR: begin
				next_r.ir_sh = `SBT_IR_CAPTURE; // R13
			end
			sbt_pkg::ST_SH_IR: begin
				next_r.ir_sh = {tdi, r.ir_sh[`SBT_IR_W-1:1]}; // R4 R11
			end
			sbt_pkg::ST_UPD_IR: begin
				next_r.instr = r.ir_sh; // R14
				next_r.upd_tgl = ~r.upd_tgl;
			end
			sbt_pkg::ST_CAP_DR: begin
				case (sel)
					sbt_pkg::SEL_BYP: next_r.bypass = `SBT_BYPASS_CAPTURE; // R16
					sbt_pkg::SEL_ID: next_r.id_sh = ID_CODE; // R20
					sbt_pkg::SEL_BSR: begin
						next_r.bsr_sh.ring = r.filt; // R17 R18 R19 R23
						next_r.bsr_sh.oe_cell = r.preload.oe_cell;
					end
					default: next_r.bypass = `SBT_BYPASS_CAPTURE;
				endcase
			end
			sbt_pkg::ST_SH_DR: begin
				case (sel)
					sbt_pkg::SEL_BYP: next_r.bypass = tdi; // R25
					sbt_pkg::SEL_ID: next_r.id_sh = {tdi, r.id_sh[`SBT_ID_W-1:1]}; // R4 R20
					sbt_pkg::SEL_BSR: next_r.bsr_sh = {tdi, r.bsr_sh[`SBT_BSR_LEN-1:1]}; // R4 R18
					default: next_r.bypass = tdi;
				endcase
			end
			sbt_pkg::ST_UPD_DR: begin
				// Preload ring cells hold until the next update under external test or sample/preload
				if (loads_preload(r.instr)) begin
					next_r.preload = r.bsr_sh; // R23
					next_r.upd_tgl = ~r.upd_tgl;
				end
			end
			default: begin
			end
		endcase
		// Entering reset restores the identification instruction and control cell
		if ((next_r.state == sbt_pkg::ST_TLR) && (r.state != sbt_pkg::ST_TLR)) begin
			next_r.instr = `SBT_OP_IDCODE; // R6 R12
			next_r.preload.oe_cell = `SBT_OE_CELL_RST; // R24
			next_r.upd_tgl = ~r.upd_tgl;
		end
	end

	// Power-up reset lands in test-logic-reset, which a pulled-high mode select keeps
	always_ff @(posedge tck or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.state <= sbt_pkg::ST_TLR; // R3 R8
			r.instr <= `SBT_OP_IDCODE; // R12
			r.preload.oe_cell <= `SBT_OE_CELL_RST; // R24
		end else begin
			r <= next_r; // R1
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Scan clock falling edge: serial output and its driver enable

	sbt_pkg::sbt_fall_t f;
	sbt_pkg::sbt_fall_t next_f;

	// Only the selected register's LSB reaches the output
	always_comb begin
		next_f.tdo_oe = (r.state == sbt_pkg::ST_SH_IR) || (r.state == sbt_pkg::ST_SH_DR); // R5
		next_f.tdo = 1'h0;
		if (r.state == sbt_pkg::ST_SH_IR) begin
			next_f.tdo = r.ir_sh[0]; // R4
		end else if (r.state == sbt_pkg::ST_SH_DR) begin
			case (sel)
				sbt_pkg::SEL_ID: next_f.tdo = r.id_sh[0]; // R10
				sbt_pkg::SEL_BSR: next_f.tdo = r.bsr_sh[0];
				default: next_f.tdo = r.bypass;
			endcase
		end
	end

	// Driver stays off from power-up until the first shift state
	always_ff @(negedge tck or negedge reset_n) begin
		if (!reset_n) begin
			f <= '0; // R8
		end else begin
			f <= next_f; // R1
		end
	end

	assign tdo = f.tdo;
	assign tdo_oe = f.tdo_oe;

	////////////////////////////////////////////////////////////////////////////
	// System clock domain: pin steering

	sbt_pkg::sbt_sys_t c;
	sbt_pkg::sbt_sys_t next_c;

	// A toggle marks each Update-IR, preload update and reset entry; the words it guards hold for a full scan period after it
	always_comb begin
		next_c = c;
		next_c.tgl_s1 = r.upd_tgl;
		next_c.tgl_s2 = c.tgl_s1;
		next_c.tgl_s3 = c.tgl_s2;
		if ((c.tgl_s2 == c.tgl_s3) && (c.tgl_s3 != c.tgl_seen)) begin
			next_c.tgl_seen = c.tgl_s3;
			next_c.instr = r.instr;
			next_c.preload = r.preload;
		end
		// Pins follow the memory core except under the two test instructions that seize them
		case (c.instr)
			`SBT_OP_EXTEST: begin
				next_c.pin_out = c.preload.ring.io; // R21
				next_c.pin_oe = c.preload.oe_cell; // R24
			end
			`SBT_OP_SAMPLE_Z: begin
				next_c.pin_out = func_out;
				next_c.pin_oe = 1'h0; // R22
			end
			default: begin
				next_c.pin_out = func_out; // R7
				next_c.pin_oe = func_oe;
			end
		endcase
	end

	// Register stage keeps one clock of latency on every pin path
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			c <= '0;
			c.instr <= `SBT_OP_IDCODE;
			c.preload.oe_cell <= `SBT_OE_CELL_RST;
		end else begin
			c <= next_c;
		end
	end

	assign pin_out = c.pin_out;
	assign pin_oe = c.pin_oe;

endmodule : sbt_tap

// [test/sbt_tap_assertions.sv]
`timescale 1ns/1ps
`include "sbt_cfg.svh"

module sbt_tap_assertions (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [`SBT_N_IO-1:0] func_out,
	input wire logic func_oe,
	input wire logic [`SBT_N_IO-1:0] pin_out,
	input wire logic pin_oe
);
	logic [1:0] age;
	logic fresh;

	////////////////////////////////////////////////////////////////////////////
	// Age since reset and whether the scan clock has moved; pins are judged as following the core only once settled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			age <= 2'h0;
			fresh <= 1'h1;
		end else begin
			age <= (age == 2'h3) ? age : age + 2'h1;
			fresh <= fresh & ~tck;
		end
	end

	// Any five ones on mode select end in the reset state
	sequence five_ones;
		tms [*5];
	endsequence

	////////////////////////////////////////////////////////////////////////////
	tdo_idle_zero_a: assert property (@(negedge tck) disable iff (!reset_n) !tdo_oe |-> !tdo)
		else $error("serial out not low while undriven");
	tdo_hold_high_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tck && $past(tck)) |-> $stable({tdo, tdo_oe})) else $error("serial out moved while scan clock high");
	tdo_hold_low_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!tck && !$past(tck)) |-> $stable({tdo, tdo_oe})) else $error("serial out moved while scan clock low");
	tms_reset_a: assert property (@(negedge tck) disable iff (!reset_n) five_ones |-> ##1 (!tdo_oe && !tdo))
		else $error("five mode ones did not reset");
	shift_exit_a: assert property (@(negedge tck) disable iff (!reset_n) (tdo_oe && tms) |=> !tdo_oe)
		else $error("shift state not left on mode one");
	shift_stay_a: assert property (@(negedge tck) disable iff (!reset_n) (tdo_oe && !tms) |=> tdo_oe)
		else $error("shift state left on mode zero");
	pin_follow_a: assert property (@(posedge clk) disable iff (!reset_n) (age == 2'h3 && fresh)
		|-> (pin_out == $past(func_out) && pin_oe == $past(func_oe))) else $error("pins not following core");
	pin_reset_a: assert property (@(posedge clk) disable iff (!reset_n) $rose(reset_n)
		|-> (!pin_oe && pin_out == '0)) else $error("pins driven out of reset");
endmodule : sbt_tap_assertions

bind sbt_tap sbt_tap_assertions u_sbt_tap_assertions (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms),
	.tdo(tdo), .tdo_oe(tdo_oe), .func_out(func_out), .func_oe(func_oe), .pin_out(pin_out), .pin_oe(pin_oe));

// [test/sbt_jtag_ctrl.sv]
`timescale 1ns/1ps

module sbt_jtag_ctrl (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	////////////////////////////////////////////////////////////////////////////
	// Scan clock parked low outside frames; lines released read as their pull-ups
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
	end

	// One scan clock; serial out is read just before the rise that consumes it
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#40;
		o = tdo_oe ? tdo : 1'hz;
		tck = 1'h1;
		#80;
		tck = 1'h0;
		#20;
		tms = 1'h1;
		tdi = 1'h1;
		#20;
	endtask : step

	// Five mode ones from anywhere, then park in idle
	task automatic tap_reset();
		logic o;
		repeat (5) step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
	endtask : tap_reset

	// From idle: capture, shift n bits LSB first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [85:0] din, output logic [85:0] dout);
		logic o;
		dout = '0;
		step(1'h1, 1'h1, o);
		if (ir) step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
		step(1'h0, 1'h1, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
	endtask : scan
endmodule : sbt_jtag_ctrl

// [test/testbench.sv]
`timescale 1ns/1ps
`include "sbt_cfg.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("mismatch %0t %0h %0h", $time, got, exp); end end

module testbench;
	logic clk;
	logic reset_n;
	wire logic tck;
	wire logic tms;
	wire logic tdi;
	logic tdo;
	logic tdo_oe;
	sbt_pkg::sbt_ring_t ring_in;
	logic [`SBT_N_IO-1:0] func_out;
	logic func_oe;
	logic [`SBT_N_IO-1:0] pin_out;
	logic pin_oe;
	logic [85:0] d;
	int fail_count;
	int num_checks;
	localparam logic [84:0] ring_pat = {17{5'h19}};
	localparam logic [85:0] pre_pat = {1'h1, ~ring_pat};

	sbt_tap u_sbt_tap (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .ring_in(ring_in), .func_out(func_out), .func_oe(func_oe), .pin_out(pin_out),
		.pin_oe(pin_oe));
	sbt_jtag_ctrl u_sbt_jtag_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	////////////////////////////////////////////////////////////////////////////
	// System clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task end_sim;
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// Out of power-up: undriven serial out, pins follow core, identification code selected
	task t_idcode;
		`CHK(tdo_oe, 1'h0)
		`CHK(pin_out, func_out)
		#0.7;
		u_sbt_jtag_ctrl.tap_reset();
		u_sbt_jtag_ctrl.scan(1'h0, 32, '0, d);
		`CHK(d[31:0], `SBT_ID_DEFAULT)
	endtask : t_idcode

	// Bypass gives a one-stage path that captures low; each instruction scan reads back the capture pattern
	task t_bypass;
		logic [3:0] pats [4];
		pats = '{4'hA, 4'h5, 4'hF, 4'h3};
		foreach (pats[i]) begin
			u_sbt_jtag_ctrl.scan(1'h1, 3, {83'h0, `SBT_OP_BYPASS}, d);
			`CHK(d[2:0], `SBT_IR_CAPTURE)
			u_sbt_jtag_ctrl.scan(1'h0, 4, {82'h0, pats[i]}, d);
			`CHK(d[3:0], ({pats[i][2:0], 1'h0}))
		end
	endtask : t_bypass

	// Sample then drive, float, tms reset, drive again from the held preload
	task t_boundary;
		u_sbt_jtag_ctrl.scan(1'h1, 3, {83'h0, `SBT_OP_SAMPLE}, d);
		u_sbt_jtag_ctrl.scan(1'h0, 86, pre_pat, d);
		`CHK(d, {1'h1, ring_pat})
		u_sbt_jtag_ctrl.scan(1'h1, 3, {83'h0, `SBT_OP_EXTEST}, d);
		`CHK(pin_out, pre_pat[35:0])
		`CHK(pin_oe, 1'h1)
		u_sbt_jtag_ctrl.scan(1'h0, 86, {1'h0, pre_pat[84:0]}, d);
		`CHK(d, {1'h1, ring_pat})
		`CHK(pin_oe, 1'h0)
		u_sbt_jtag_ctrl.scan(1'h1, 3, {83'h0, `SBT_OP_SAMPLE_Z}, d);
		`CHK(pin_oe, 1'h0)
		u_sbt_jtag_ctrl.tap_reset();
		`CHK({pin_oe, pin_out}, {func_oe, func_out})
		u_sbt_jtag_ctrl.scan(1'h1, 3, {83'h0, `SBT_OP_EXTEST}, d);
		`CHK({pin_oe, pin_out}, {1'h1, pre_pat[35:0]})
	endtask : t_boundary

	////////////////////////////////////////////////////////////////////////////
	// Main sequence; pin-side inputs change just after a system clock rise
	initial begin
		fail_count = 0;
		num_checks = 0;
		reset_n = 1'h0;
		ring_in = '0;
		func_out = '0;
		func_oe = 1'h0;
		repeat (6) @(posedge clk);
		#1;
		reset_n = 1'h1;
		ring_in = ring_pat;
		func_out = 36'h95A5A5A5A;
		func_oe = 1'h1;
		repeat (3) @(posedge clk);
		#1;
		t_idcode();
		t_bypass();
		t_boundary();
		end_sim();
	end

	// Hang guard, well past the scan traffic above
	initial begin
		#300000;
		fail_count++;
		end_sim();
	end
endmodule : testbench
